/* File: sim/scrg_rate_gen_sva.sv */
// Purpose: port-level checker for scrg_rate_gen
// Assumes: source pins are slow against core_clk
// Notes:   ratio check skips the period after a ratio change
`timescale 1ns/1ps
module scrg_chk(input wire core_clk, rst_n, crystal_clock_in, external_clock_pin,
	serial_clock_pin, external_clock_select, two_wire_mode, analog_master_clock,
	digital_sample_clock, output_rate_clock, data_ready_strobe_n,
	input wire [1:0] prescale_field, input wire [2:0] oversampling_ratio_field);
	wire s = two_wire_mode ? serial_clock_pin : external_clock_select ? external_clock_pin
		: crystal_clock_in;
	reg sd, sa, so;
	reg [1:0] ac, lo;
	reg [12:0] dc;
	reg [2:0] od;
	always @(posedge core_clk or negedge rst_n)
		if (!rst_n)
			{sd, sa, so, ac, lo, dc, od} <= 0;
		else
			{sd, sa, so, ac, lo, dc, od} <= {s, sa | digital_sample_clock,
				(so | output_rate_clock) & (oversampling_ratio_field == od),
				digital_sample_clock ? 2'h0 : ac + analog_master_clock,
				data_ready_strobe_n ? 2'h0 : lo + analog_master_clock,
				output_rate_clock ? 13'h0 : dc + digital_sample_clock, oversampling_ratio_field};
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	amc_cause_a: assert property (analog_master_clock |-> $past(s & ~sd, 1) || $past(s & ~sd, 2)
		|| $past(s & ~sd, 3)) else $error("analog pulse without tick");
	amc_pulse_a: assert property (analog_master_clock |=> !analog_master_clock)
		else $error("analog pulse too long");
	dsc_on_amc_a: assert property (digital_sample_clock |-> analog_master_clock)
		else $error("sample pulse off analog");
	dsc_fourth_a: assert property (digital_sample_clock && sa |-> ac == 2'h3)
		else $error("sample not every fourth");
	orc_on_dsc_a: assert property (output_rate_clock |-> digital_sample_clock)
		else $error("output pulse off sample");
	orc_ratio_a: assert property (output_rate_clock && so |-> dc == (13'h20 << od) - 13'h1)
		else $error("wrong sample count");
	drdy_start_a: assert property (output_rate_clock |=> !data_ready_strobe_n)
		else $error("strobe not low");
	drdy_width_a: assert property ($rose(data_ready_strobe_n) |-> lo == 2'h2)
		else $error("strobe width wrong");
endmodule // scrg_chk
bind scrg_rate_gen scrg_chk u_scrg_chk (.*);

/* File: sim/scrg_src_model.sv */
// Purpose: clock sources at the far side of the block
// Assumes: crystal toggles each cycle, external pin every 2, serial clock every 3
// Notes:   the serial clock never stops, so two-wire mode is safe
`timescale 1ns/1ps
module scrg_src(input wire core_clk, output reg xtal = 1'b0, output reg ext = 1'b1,
	output reg sck = 1'b0);
	// distinct source periods make a wrong source choice show up as a wrong rate
	reg       ec = 1'b0;
	reg [1:0] sc = 2'h0;
	always @(posedge core_clk)
	begin
		xtal <= ~xtal;
		ec <= ~ec;
		if (ec)
			ext <= ~ext;
		sc <= (sc == 2'h2) ? 2'h0 : sc + 2'h1;
		if (sc == 2'h2)
			sck <= ~sck;
	end
endmodule // scrg_src

/* File: sim/tb.sv */
// Purpose: self-checking bench for scrg_rate_gen
// Assumes: master tick every 2 cycles on crystal, 4 on external pin, 6 on serial clock
// Notes:   each row measures one full period and its sum
`timescale 1ns/1ps
module tb;
	reg core_clk = 1'b0, rst_n = 1'b0, tw = 1'b0, sel = 1'b0;
	reg [1:0] pre = 2'h0, mb = 2'h1;
	reg [2:0] osr = 3'h3;
	wire x, e, s, amc, dsc, orc, drn;
	wire [25:0] res;
	integer bad_count = 0, num_checks = 0, n, i;
	reg [24:0] rows [0:8];
	always #2.5 core_clk = ~core_clk;
	scrg_src u_scrg_src(.core_clk(core_clk), .xtal(x), .ext(e), .sck(s));
	scrg_rate_gen u_scrg_rate_gen(.core_clk(core_clk), .rst_n(rst_n), .crystal_clock_in(x),
		.external_clock_pin(e), .serial_clock_pin(s), .external_clock_select(sel),
		.two_wire_mode(tw), .prescale_field(pre), .oversampling_ratio_field(osr),
		.modulator_bit(mb), .analog_master_clock(amc), .digital_sample_clock(dsc),
		.output_rate_clock(orc), .data_ready_strobe_n(drn), .conversion_result(res));
	task chk(input [31:0] got, input [31:0] exp);
	begin
		num_checks = num_checks + 1;
		if (got !== exp)
		begin
			bad_count = bad_count + 1;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task wo(output integer k);
	begin
		k = 0;
		@(posedge core_clk);
		while (orc !== 1'b1 && k < 40000)
		begin
			k = k + 1;
			@(posedge core_clk);
		end
	end
	endtask
	task report_and_stop;
	begin
		$display("checks=%0d mismatches=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
	endtask
	initial
	begin
		#400000;
		bad_count = bad_count + 1;
		report_and_stop;
	end
	initial
	begin
		// rows {modulator bits, two-wire, select, prescale, ratio, period in core cycles}
		// row 2 checks the two-wire override; row 0 shows the serial clock ignored in spi mode
		rows[0] = {2'h1, 1'b0, 1'b0, 2'h0, 3'h0, 16'h0100};
		rows[1] = {2'h2, 1'b0, 1'b1, 2'h1, 3'h0, 16'h0400};
		rows[2] = {2'h3, 1'b1, 1'b1, 2'h2, 3'h0, 16'h0c00};
		rows[3] = {2'h1, 1'b0, 1'b0, 2'h3, 3'h0, 16'h0800};
		rows[4] = {2'h2, 1'b0, 1'b1, 2'h0, 3'h1, 16'h0400};
		rows[5] = {2'h1, 1'b0, 1'b1, 2'h0, 3'h2, 16'h0800};
		rows[6] = {2'h3, 1'b0, 1'b1, 2'h0, 3'h3, 16'h1000};
		rows[7] = {2'h1, 1'b0, 1'b0, 2'h0, 3'h4, 16'h1000};
		rows[8] = {2'h2, 1'b0, 1'b0, 2'h0, 3'h5, 16'h2000};
		repeat (10) @(posedge core_clk);
		chk({drn, amc, res}, 32'h8000000);
		for (i = 0; i < 9; i = i + 1)
		begin
			{mb, tw, sel, pre, osr} <= rows[i][24:16];
			rst_n <= 1'b1;
			wo(n);
			wo(n);
			chk(n + 1, {16'h0, rows[i][15:0]});
			chk(res, {(mb[1] ? 13'h20 << osr : 13'h0), (mb[0] ? 13'h20 << osr : 13'h0)});
		end
		rst_n <= 1'b0;
		@(posedge core_clk);
		@(negedge core_clk);
		chk({drn, amc, res}, 32'h8000000);
		@(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		@(negedge core_clk);
		chk(drn, 32'h0);
		report_and_stop;
	end
endmodule // tb

/* File: verilog/scrg_defs.vh */
// Purpose: constants for the sampling clock rate generator
// Assumes: plain Verilog-2005 includer
// Notes:   divisor codes are log2 values, the ratio code relative to 32
`ifndef SCRG_DEFS_VH
`define SCRG_DEFS_VH

`define SCRG_SRC_XTAL        1'b0
`define SCRG_SRC_EXT         1'b1
`define SCRG_PRE_W           2
`define SCRG_PRE_CNT_W       3
`define SCRG_PRE_RST         2'h0
`define SCRG_DM_DIV_W        2
`define SCRG_DM_HALF         2'h2
`define SCRG_OSR_W           3
`define SCRG_OSR_CNT_W       12
`define SCRG_OSR_RST         3'h3
`define SCRG_OSR_MIN         12'h020
`define SCRG_ACC_W           13
`define SCRG_NUM_CH          2

`endif

/* File: verilog/scrg_rate_gen.v */
// Purpose: master clock selection, prescaler, sample and output rate dividers
// Assumes: all clock source pins sampled on core_clk, which is much faster
// Notes:   derived clocks are one-cycle enables on core_clk
`timescale 1ns/1ps
`include "scrg_defs.vh"

// Operation
// R1 - master clock: crystal, external pin, or serial clock
// R2 - host keeps serial clock running in two-wire
// R3 - serial clock independent; master clock must keep running
// R4 - prescale divides master clock by 1,2,4,8
// R5 - prescaled clock drives gain stages and modulators
// R6 - sample clock is analog clock divided by four
// R7 - output rate is sample clock over ratio
// R8 - output period is 4 x ratio x prescale
// R9 - sinc decimation, notches at output rate multiples
// R10 - ratio code selects 32 to 4096, doubling
// R11 - data-ready low half sample period, once per output
// R12 - dividers synchronous counters on master clock, reset
module scrg_rate_gen
(
	input  wire                                   core_clk,
	input  wire                                   rst_n,
	input  wire                                   crystal_clock_in,
	input  wire                                   external_clock_pin,
	input  wire                                   serial_clock_pin,
	input  wire                                   external_clock_select,
	input  wire                                   two_wire_mode,
	input  wire [`SCRG_PRE_W-1:0]                 prescale_field,
	input  wire [`SCRG_OSR_W-1:0]                 oversampling_ratio_field,
	input  wire [`SCRG_NUM_CH-1:0]                modulator_bit,
	output reg                                    analog_master_clock,
	output reg                                    digital_sample_clock,
	output reg                                    output_rate_clock,
	output reg                                    data_ready_strobe_n,
	output reg  [`SCRG_NUM_CH*`SCRG_ACC_W-1:0]    conversion_result
);

	// source edge detector
	reg                                      src_prev_reg;
	reg                                      src_level;
	wire                                     mclk_tick;

	// divider counters and their next values
	reg  [`SCRG_PRE_CNT_W-1:0]               pre_cnt_reg;
	reg  [`SCRG_PRE_CNT_W-1:0]               pre_cnt_next;
	reg  [`SCRG_DM_DIV_W-1:0]                dm_cnt_reg;
	reg  [`SCRG_DM_DIV_W-1:0]                dm_cnt_next;
	reg  [`SCRG_OSR_CNT_W-1:0]               osr_cnt_reg;
	reg  [`SCRG_OSR_CNT_W-1:0]               osr_cnt_next;

	// terminal counts and one-cycle enables
	wire [`SCRG_PRE_CNT_W-1:0]               pre_max;
	wire [`SCRG_OSR_CNT_W-1:0]               osr_max;
	wire                                     am_tick;
	wire                                     dm_tick;
	wire                                     dr_tick;

	// next values of the registered outputs
	reg                                      amc_next;
	reg                                      dsc_next;
	reg                                      orc_next;
	reg                                      drdy_n_next;
	wire [`SCRG_NUM_CH*`SCRG_ACC_W-1:0]      sum_final;

	// two-wire mode overrides the select bit: the serial pin is the only clock then
	always @*
	begin
		if (two_wire_mode)
			src_level = serial_clock_pin; // [R1]
		else if (external_clock_select == `SCRG_SRC_EXT)
			src_level = external_clock_pin; // [R1]
		else
			src_level = crystal_clock_in; // [R1]
	end

	// only edges of the chosen source advance anything; the serial clock in spi mode never does
	assign mclk_tick = src_level & ~src_prev_reg; // [R3]

	// a shift past the top bit wraps to zero, so minus one still gives the all-ones count
	assign pre_max = (`SCRG_PRE_CNT_W'h1 << prescale_field) - `SCRG_PRE_CNT_W'h1; // [R4]
	assign osr_max = (`SCRG_OSR_MIN << oversampling_ratio_field) - `SCRG_OSR_CNT_W'h1; // [R10]

	assign am_tick = mclk_tick && (pre_cnt_reg >= pre_max); // [R4]
	assign dm_tick = am_tick && (dm_cnt_reg == {`SCRG_DM_DIV_W{1'b1}}); // [R6]
	assign dr_tick = dm_tick && (osr_cnt_reg >= osr_max); // [R7] [R8]

	// >= compares let a shrinking divisor wrap at once instead of running 2^n
	always @*
	begin
		pre_cnt_next = pre_cnt_reg;
		if (mclk_tick)
		begin
			if (pre_cnt_reg >= pre_max)
				pre_cnt_next = {`SCRG_PRE_CNT_W{1'b0}};
			else
				pre_cnt_next = pre_cnt_reg + `SCRG_PRE_CNT_W'h1; // [R12]
		end
	end

	always @*
	begin
		dm_cnt_next = dm_cnt_reg;
		if (am_tick)
			dm_cnt_next = dm_cnt_reg + `SCRG_DM_DIV_W'h1; // [R6] [R12]
	end

	always @*
	begin
		osr_cnt_next = osr_cnt_reg;
		if (dm_tick)
		begin
			if (osr_cnt_reg >= osr_max)
				osr_cnt_next = {`SCRG_OSR_CNT_W{1'b0}};
			else
				osr_cnt_next = osr_cnt_reg + `SCRG_OSR_CNT_W'h1; // [R12]
		end
	end

	// strobe low for the first two analog periods of each output period
	always @*
	begin
		amc_next    = am_tick; // [R5]
		dsc_next    = dm_tick; // [R6]
		orc_next    = dr_tick; // [R7]
		drdy_n_next = ~((osr_cnt_reg == {`SCRG_OSR_CNT_W{1'b0}})
			&& (dm_cnt_reg < `SCRG_DM_HALF)); // [R11]
	end

	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			src_prev_reg <= 1'b0;
			pre_cnt_reg  <= {`SCRG_PRE_CNT_W{1'b0}};
			dm_cnt_reg   <= {`SCRG_DM_DIV_W{1'b0}};
			osr_cnt_reg  <= {`SCRG_OSR_CNT_W{1'b0}};
		end
		else
		begin
			src_prev_reg <= src_level;
			pre_cnt_reg  <= pre_cnt_next;
			dm_cnt_reg   <= dm_cnt_next;
			osr_cnt_reg  <= osr_cnt_next;
		end
	end

	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			analog_master_clock  <= 1'b0;
			digital_sample_clock <= 1'b0;
			output_rate_clock    <= 1'b0;
			data_ready_strobe_n  <= 1'b1;
		end
		else
		begin
			analog_master_clock  <= amc_next;
			digital_sample_clock <= dsc_next;
			output_rate_clock    <= orc_next;
			data_ready_strobe_n  <= drdy_n_next;
		end
	end

	// first-order sinc: boxcar sum over one output period, notch at every rate multiple
	genvar ch;
	generate
		for (ch = 0; ch < `SCRG_NUM_CH; ch = ch + 1)
		begin : g_dec
			reg  [`SCRG_ACC_W-1:0] acc_reg;
			wire [`SCRG_ACC_W-1:0] acc_inc;

			assign acc_inc = {{(`SCRG_ACC_W-1){1'b0}}, modulator_bit[ch]};
			// the closing sample's bit belongs to the period that it ends
			assign sum_final[ch*`SCRG_ACC_W +: `SCRG_ACC_W] = acc_reg + acc_inc; // [R9]

			always @(posedge core_clk or negedge rst_n)
			begin
				if (!rst_n)
					acc_reg <= {`SCRG_ACC_W{1'b0}};
				else if (dr_tick)
					acc_reg <= {`SCRG_ACC_W{1'b0}};
				else if (dm_tick)
					acc_reg <= acc_reg + acc_inc; // [R9]
			end
		end
	endgenerate

	// one process owns the whole result word, so every bit has a single driver
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			conversion_result <= {(`SCRG_NUM_CH*`SCRG_ACC_W){1'b0}};
		else if (dr_tick)
			conversion_result <= sum_final; // [R7] [R9]
	end

endmodule // scrg_rate_gen
